/* rtl/lhe_pkg.sv */
// Constants for the host access error status block
package lhe_pkg;
    localparam int unsigned           ADDR_W          = 8;
    localparam int unsigned           DATA_W          = 32;
    localparam int unsigned           NUM_WIN         = 8;
    // Register offsets (byte addresses)
    localparam logic [7:0]            STATUS_OFS      = 8'h08;
    localparam logic [7:0]            IRQ_STAT_OFS    = 8'h20;
    localparam logic [7:0]            IRQ_MASK_OFS    = 8'h24;
    // Field positions in the status register
    localparam int unsigned           ERR_FLAG_BIT    = 0;
    localparam int unsigned           FAULT_EN_BIT    = 1;
    localparam int unsigned           OVERLAP_BIT     = 2;
    // Interrupt status and mask layout
    localparam int unsigned           IRQ_ERR_BIT     = 0;
    localparam int unsigned           IRQ_OVL_BIT     = 1;
    localparam int unsigned           IRQ_W           = 2;
    // Reset values
    localparam logic [2:0]            STATUS_RST      = 3'h0;
    localparam logic [1:0]            IRQ_STAT_RST    = 2'h0;
    localparam logic [1:0]            IRQ_MASK_RST    = 2'h0;
endpackage

/* rtl/lhe_overlap_detect.sv */
// Counts simultaneous window matches and flags two or more
`timescale 1ns/10ps
module lhe_overlap_detect (
    input  wire logic [lhe_pkg::NUM_WIN-1:0] win_match,
    output logic                             overlap
);
    logic [lhe_pkg::NUM_WIN-1:0] seen_one;
    logic [lhe_pkg::NUM_WIN-1:0] seen_two;

    // Running "at least one" and "at least two" chains
    genvar i;
    generate
        for (i = 0; i < lhe_pkg::NUM_WIN; i++) begin : g_win
            if (i == 0) begin : g_first
                assign seen_one[i] = win_match[i];
                assign seen_two[i] = 1'b0;
            end else begin : g_rest
                assign seen_one[i] = seen_one[i-1] | win_match[i];
                assign seen_two[i] = seen_two[i-1] | (seen_one[i-1] & win_match[i]);
            end
        end
    endgenerate

    assign overlap = seen_two[lhe_pkg::NUM_WIN-1];
endmodule

/* rtl/lhe_host_error_status.sv */
// Host access error status register with interrupt logic
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module lhe_host_error_status (
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic [lhe_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic [lhe_pkg::DATA_W-1:0]       reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic      [lhe_pkg::DATA_W-1:0]       reg_rdata,
    input  wire logic                             lpc_cycle,
    input  wire logic [lhe_pkg::NUM_WIN-1:0]      win_match,
    input  wire logic                             bus_fault,
    output logic                                  host_access_error_flag,
    output logic                                  irq
);
    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic                 overlap_raw;
    logic                 overlap_ev;
    logic                 fault_ev;
    logic                 err_ev;
    logic                 fault_en_q;
    logic                 overlap_q;
    logic                 err_q;
    logic [lhe_pkg::IRQ_W-1:0] irq_stat_q;
    logic [lhe_pkg::IRQ_W-1:0] irq_mask_q;
    logic [lhe_pkg::IRQ_W-1:0] irq_ev;
    logic                 wr_status;
    logic                 wr_mask;
    logic                 rd_irq_stat;

    lhe_overlap_detect u_overlap (
        .win_match (win_match),
        .overlap   (overlap_raw)
    );

    assign overlap_ev = lpc_cycle & overlap_raw;
    // Bus faults only count when reporting is enabled
    assign fault_ev   = lpc_cycle & bus_fault & fault_en_q;
    assign err_ev     = overlap_ev | fault_ev;

    assign wr_status   = reg_wr & (reg_addr == lhe_pkg::STATUS_OFS);
    assign wr_mask     = reg_wr & (reg_addr == lhe_pkg::IRQ_MASK_OFS);
    assign rd_irq_stat = reg_rd & (reg_addr == lhe_pkg::IRQ_STAT_OFS);

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_en_q <= lhe_pkg::STATUS_RST[lhe_pkg::FAULT_EN_BIT];
        end else if (wr_status) begin
            fault_en_q <= reg_wdata[lhe_pkg::FAULT_EN_BIT];
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overlap_q <= lhe_pkg::STATUS_RST[lhe_pkg::OVERLAP_BIT];
        end else if (overlap_ev) begin
            overlap_q <= 1'b1;
        end else if (wr_status && reg_wdata[lhe_pkg::OVERLAP_BIT]) begin
            overlap_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_q <= lhe_pkg::STATUS_RST[lhe_pkg::ERR_FLAG_BIT];
        end else if (err_ev) begin
            err_q <= 1'b1;
        end else if (wr_status && reg_wdata[lhe_pkg::ERR_FLAG_BIT]) begin
            err_q <= 1'b0;
        end
    end

    assign host_access_error_flag = err_q;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        irq_ev                      = '0;
        irq_ev[lhe_pkg::IRQ_ERR_BIT] = err_ev;
        irq_ev[lhe_pkg::IRQ_OVL_BIT] = overlap_ev;
    end

    // Read clears, but an event in the read cycle survives
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= lhe_pkg::IRQ_STAT_RST;
        end else if (rd_irq_stat) begin
            irq_stat_q <= irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= lhe_pkg::IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask_q <= reg_wdata[lhe_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                lhe_pkg::STATUS_OFS: begin
                    reg_rdata[lhe_pkg::ERR_FLAG_BIT] <= err_q;
                    reg_rdata[lhe_pkg::FAULT_EN_BIT] <= fault_en_q;
                    reg_rdata[lhe_pkg::OVERLAP_BIT]  <= overlap_q;
                end
                lhe_pkg::IRQ_STAT_OFS: begin
                    reg_rdata[lhe_pkg::IRQ_W-1:0] <= irq_stat_q;
                end
                lhe_pkg::IRQ_MASK_OFS: begin
                    reg_rdata[lhe_pkg::IRQ_W-1:0] <= irq_mask_q;
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    overlap_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
        (lpc_cycle && overlap_raw) |=> overlap_q && err_q)
        else $error("overlap did not set flags");

    overlap_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
        (overlap_q && !(wr_status && reg_wdata[lhe_pkg::OVERLAP_BIT])) |=> overlap_q)
        else $error("overlap flag dropped without clear");

    fault_masked_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!err_q && !fault_en_q && !(lpc_cycle && overlap_raw)) |=> !err_q)
        else $error("error flag set while faults disabled");

    fault_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
        (lpc_cycle && bus_fault && fault_en_q) |=> err_q)
        else $error("enabled bus fault did not set error flag");

    err_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(err_q) |-> $past(lpc_cycle) && ($past(overlap_raw) || $past(bus_fault)))
        else $error("error flag rose without cause");

    err_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_status && reg_wdata[lhe_pkg::ERR_FLAG_BIT] && !err_ev) |=> !err_q)
        else $error("write one did not clear error flag");

    zero_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_status && !reg_wdata[lhe_pkg::ERR_FLAG_BIT] && err_q) |=> err_q)
        else $error("write zero cleared error flag");

    irq_source_a: assert property (@(posedge clk) disable iff (!arst_n)
        (err_ev && irq_mask_q[lhe_pkg::IRQ_ERR_BIT] && !wr_mask) |=> irq)
        else $error("unmasked error did not raise interrupt");

    fault_en_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_status |=> fault_en_q == $past(reg_wdata[lhe_pkg::FAULT_EN_BIT]))
        else $error("fault enable write not taken");

    fault_en_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !wr_status |=> $stable(fault_en_q))
        else $error("fault enable changed without write");

    fault_disabled_a: assert property (@(posedge clk) disable iff (!arst_n)
        (lpc_cycle && bus_fault && !fault_en_q && $onehot0(win_match) && !err_q)
        |=> !err_q)
        else $error("disabled bus fault set error flag");

    ovl_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_status && reg_wdata[lhe_pkg::OVERLAP_BIT] && !overlap_ev) |=> !overlap_q)
        else $error("write one did not clear overlap flag");

    ovl_zero_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_status && !reg_wdata[lhe_pkg::OVERLAP_BIT] && overlap_q) |=> overlap_q)
        else $error("write zero cleared overlap flag");

    ovl_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(overlap_q) |-> $past(lpc_cycle) && !$onehot0($past(win_match)))
        else $error("overlap flag rose without cause");

    err_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
        (err_q && !(wr_status && reg_wdata[lhe_pkg::ERR_FLAG_BIT])) |=> err_q)
        else $error("error flag dropped without clear");

    set_beats_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (err_ev && wr_status) |=> err_q)
        else $error("clear won over error event");

    ovl_beats_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (overlap_ev && wr_status) |=> overlap_q)
        else $error("clear won over overlap event");

    idle_no_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!lpc_cycle && !err_q) |=> !err_q)
        else $error("error flag set outside a cycle");

    single_match_a: assert property (@(posedge clk) disable iff (!arst_n)
        (lpc_cycle && $onehot0(win_match) && !overlap_q) |=> !overlap_q)
        else $error("single match set overlap flag");

    multi_match_a: assert property (@(posedge clk) disable iff (!arst_n)
        (lpc_cycle && !$onehot0(win_match)) |=> overlap_q && err_q)
        else $error("multiple matches did not set flags");

    irq_err_event_a: assert property (@(posedge clk) disable iff (!arst_n)
        err_ev |=> irq_stat_q[lhe_pkg::IRQ_ERR_BIT])
        else $error("error event not latched for interrupt");

    irq_ovl_event_a: assert property (@(posedge clk) disable iff (!arst_n)
        overlap_ev |=> irq_stat_q[lhe_pkg::IRQ_OVL_BIT])
        else $error("overlap event not latched for interrupt");

    irq_stat_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        (irq_stat_q[lhe_pkg::IRQ_ERR_BIT] && !rd_irq_stat)
        |=> irq_stat_q[lhe_pkg::IRQ_ERR_BIT])
        else $error("error interrupt status dropped");

    irq_ovl_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
        (irq_stat_q[lhe_pkg::IRQ_OVL_BIT] && !rd_irq_stat)
        |=> irq_stat_q[lhe_pkg::IRQ_OVL_BIT])
        else $error("overlap interrupt status dropped");

    irq_read_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_irq_stat && !err_ev) |=> !irq_stat_q[lhe_pkg::IRQ_ERR_BIT])
        else $error("read did not clear error status");

    irq_ovl_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_irq_stat && !overlap_ev) |=> !irq_stat_q[lhe_pkg::IRQ_OVL_BIT])
        else $error("read did not clear overlap status");

    irq_masked_a: assert property (@(posedge clk) disable iff (!arst_n)
        (irq_mask_q == '0) |-> !irq)
        else $error("interrupt raised while fully masked");

    mask_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_mask |=> irq_mask_q == $past(reg_wdata[lhe_pkg::IRQ_W-1:0]))
        else $error("mask write not taken");

    mask_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !wr_mask |=> $stable(irq_mask_q))
        else $error("mask changed without write");

    rd_status_a: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == lhe_pkg::STATUS_OFS)
        |=> reg_rdata[lhe_pkg::OVERLAP_BIT:0] == $past({overlap_q, fault_en_q, err_q}))
        else $error("status read data wrong");

    rd_upper_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == lhe_pkg::STATUS_OFS)
        |=> reg_rdata[lhe_pkg::DATA_W-1:lhe_pkg::OVERLAP_BIT+1] == '0)
        else $error("status upper bits not zero");

    rd_irq_stat_a: assert property (@(posedge clk) disable iff (!arst_n)
        rd_irq_stat |=> reg_rdata[lhe_pkg::IRQ_W-1:0] == $past(irq_stat_q))
        else $error("interrupt status read data wrong");
endmodule

/* sim/lhe_lpc_host_model.sv */
// Behavioural host controller that issues decoded I/O cycles
`timescale 1ns/10ps
module lhe_lpc_host_model (
    input  wire logic                        clk,
    output logic                             lpc_cycle,
    output logic [lhe_pkg::NUM_WIN-1:0]      win_match,
    output logic                             bus_fault
);
    initial begin
        lpc_cycle = 1'b0;
        win_match = 8'h00;
        bus_fault = 1'b0;
    end
    // Idle lines flip to the inverse so a stale match is never mistaken for a cycle
    task automatic io(input logic [lhe_pkg::NUM_WIN-1:0] win, input logic flt,
                      input int gap);
        @(posedge clk);
        lpc_cycle <= 1'b1;
        win_match <= win;
        bus_fault <= flt;
        @(posedge clk);
        lpc_cycle <= 1'b0;
        win_match <= ~win;
        bus_fault <= ~flt;
        repeat (gap) @(posedge clk);
    endtask
endmodule

/* sim/tb_lhe_host_error_status.sv */
// Self-checking bench for the host access error status block
`timescale 1ns/10ps
module tb_lhe_host_error_status;
    logic        clk       = 1'b0;
    logic        arst_n    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        lpc_cycle;
    logic [7:0]  win_match;
    logic        bus_fault;
    logic        host_access_error_flag;
    logic        irq;
    logic        rd_seen   = 1'b0;
    logic [31:0] exp_q[$];
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc       = 0;
    int          seed      = 60;
    logic [7:0]  w;
    logic        f;
    logic        o;

    always #2.5 clk = ~clk;

    lhe_host_error_status dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lpc_cycle(lpc_cycle), .win_match(win_match), .bus_fault(bus_fault),
        .host_access_error_flag(host_access_error_flag), .irq(irq));
    lhe_lpc_host_model host (.clk(clk), .lpc_cycle(lpc_cycle), .win_match(win_match),
        .bus_fault(bus_fault));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_seen <= reg_rd;
        cyc     <= cyc + 1;
        if (rd_seen) check(reg_rdata, exp_q.pop_front(), "rdata");
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h08, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h24, 32'h0);
        rd(8'h04, 32'h0);
        host.io(8'h03, 1'b0, 0);
        rd(8'h08, 32'h5);
        @(negedge clk);
        check(32'(host_access_error_flag), 32'h1, "flag");
        check(32'(irq), 32'h0, "irq");
        wr(8'h08, 32'h0);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h08, 32'h5);
        wr(8'h08, 32'h5);
        host.io(8'h80, 1'b1, 3);
        host.io(8'h01, 1'b1, 0);
        rd(8'h08, 32'h0);
        wr(8'h24, 32'h3);
        @(negedge clk);
        check(32'(irq), 32'h1, "irq");
        rd(8'h20, 32'h3);
        @(negedge clk);
        check(32'(irq), 32'h0, "irq");
        wr(8'h08, 32'h2);
        for (int i = 0; i < 24; i++) begin
            w = 8'($random(seed));
            f = 1'($random(seed));
            o = $countones(w) > 1;
            host.io(w, f, i % 3);
            rd(8'h08, {29'h0, o, 1'b1, o | f});
            wr(8'h08, 32'h7);
            rd(8'h20, {30'h0, o, o | f});
        end
        // Set beats a write-one clear in the same cycle
        fork
            host.io(8'h03, 1'b0, 0);
            wr(8'h08, 32'h5);
        join
        rd(8'h08, 32'h5);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h08, 32'h0);
        rd(8'h24, 32'h0);
        @(negedge clk);
        check(32'(host_access_error_flag), 32'h0, "flag");
        check(32'(irq), 32'h0, "irq");
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
